// File: rtl/tca_pkg.sv
// Package of constants and types for the Type-C port attach logic.
package tca_pkg;
	// Pulldown classes reported by the pin comparators.
	localparam logic [1:0] CLS_OPEN = 2'h0;
	localparam logic [1:0] CLS_SINK = 2'h1;
	localparam logic [1:0] CLS_CABLE = 2'h2;
	// Contact codes.
	localparam logic [1:0] CODE_NONE = 2'h0;
	localparam logic [1:0] CODE_CC1 = 2'h1;
	localparam logic [1:0] CODE_CC2 = 2'h2;
	// Pullup advertisement selections.
	localparam logic [1:0] RP_0A5 = 2'h0;
	localparam logic [1:0] RP_1A5 = 2'h1;
	localparam logic [1:0] RP_3A0 = 2'h2;
	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DEB = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_FAULT = 8'h0c;
	// Control register fields.
	localparam int CTRL_CFG = 0;
	localparam int CTRL_BUCK = 1;
	localparam int CTRL_RP_LO = 2;
	localparam int CTRL_VCONN = 4;
	localparam logic [31:0] CTRL_RST = 32'h0000_0002;
	// Debounce register reset value.
	localparam logic [15:0] DEB_RST = 16'h0100;
	// Status register fields.
	localparam int ST_ATT = 0;
	localparam int ST_ORI = 1;
	localparam int ST_CODE = 2;
	localparam int ST_VBUS = 4;
	localparam int ST_VC1 = 5;
	localparam int ST_VC2 = 6;
	localparam int ST_GATE = 7;
	localparam int ST_PERMIT = 8;
	localparam int ST_OVP = 9;
	localparam int ST_OCP = 10;
	localparam int ST_NCFG = 11;
	// Fault register fields, write one to clear.
	localparam int FLT_OVP = 0;
	localparam int FLT_OCP = 1;
	// Gate lead time before soft start, in microseconds.
	localparam int CLK_MHZ = 50;
	localparam int GATE_LEAD_US = 10;
	localparam int GATE_LEAD_CYC = GATE_LEAD_US * CLK_MHZ;
	localparam logic [15:0] GATE_LEAD_N = 16'(GATE_LEAD_CYC);
	// Power sequencer states.
	typedef enum logic [3:0] {
		SQ_OFF = 4'b0001,
		SQ_GATE = 4'b0010,
		SQ_RUN = 4'b0100,
		SQ_DISCH = 4'b1000
	} tca_seq_t;
endpackage

// File: rtl/tca_debounce.sv
// Debouncer that passes a vector only after it holds steady.
`timescale 1ns/10ps
`default_nettype none
module tca_debounce #(
	parameter int W = 4
) (
	input wire logic ref_clk, // System clock.
	input wire logic arst_n, // Asynchronous reset, active low.
	input wire logic clr, // Synchronous clear to zero.
	input wire logic [W-1:0] raw, // Sampled vector.
	input wire logic [15:0] limit, // Required stable cycles.
	output logic [W-1:0] stable_q // Debounced vector.
);
	logic [W-1:0] last_q;
	logic [15:0] cnt_q;

	// Restart the count whenever the sample moves.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			last_q <= '0;
			cnt_q <= '0;
		end else if (clr || raw != last_q) begin
			last_q <= raw;
			cnt_q <= '0;
		end else if (cnt_q != 16'hffff) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	// Accept the sample once it has held long enough.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			stable_q <= '0;
		end else if (clr) begin
			stable_q <= '0;
		end else if (raw == last_q && cnt_q >= limit) begin
			stable_q <= last_q;
		end
	end
endmodule // tca_debounce
`default_nettype wire

// File: rtl/tca_attach.sv
// Type-C port attach, orientation and power sequencing logic.
`timescale 1ns/10ps
`default_nettype none
module tca_attach
	import tca_pkg::*;
(
	input wire logic ref_clk, // 50 MHz system clock.
	input wire logic arst_n, // Asynchronous reset, active low.
	input wire logic wb_cyc_i, // Wishbone cycle.
	input wire logic wb_stb_i, // Wishbone strobe.
	input wire logic wb_we_i, // Wishbone write enable.
	input wire logic [7:0] wb_adr_i, // Wishbone byte address.
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
	input wire logic [31:0] wb_dat_i, // Wishbone write data.
	output logic [31:0] wb_dat_o, // Wishbone read data.
	output logic wb_ack_o, // Wishbone acknowledge.
	input wire logic [1:0] cc1_class, // CC1 pulldown class.
	input wire logic [1:0] cc2_class, // CC2 pulldown class.
	input wire logic system_wake_enable, // Main enable pin.
	input wire logic bias_uv, // Logic supply undervoltage.
	input wire logic buck_enable_pin, // Converter enable pin.
	input wire logic vconn_src_ok, // Cable power source in range.
	input wire logic vconn_ovp, // Cable power overvoltage.
	input wire logic vconn_ocp, // Cable power overcurrent.
	input wire logic disch_done, // Output discharge finished.
	output logic [1:0] rp_sel, // Pullup level on both pins.
	output logic standby, // Low consumption standby.
	output logic not_cfg_int, // Not configured indication.
	output logic ext_fet_gate_drive, // External FET gate drive.
	output logic buck_run, // Converter on, soft start.
	output logic vconn_cc1_en, // Cable power onto CC1.
	output logic vconn_cc2_en, // Cable power onto CC2.
	output logic orient_o, // Orientation pin level.
	output logic orient_oe // Orientation pin pulls low.
);
	// Two-stage synchronisers for all pin inputs.
	// A class pair can tear for one cycle when both pins move at once;
	// the debouncer downstream absorbs that.
	localparam int NS = 11;
	logic [NS-1:0] pin_raw;
	logic [NS-1:0] sync1_q;
	logic [NS-1:0] sync2_q;
	assign pin_raw = {cc1_class, cc2_class, system_wake_enable,
		bias_uv, buck_enable_pin, vconn_src_ok, vconn_ovp,
		vconn_ocp, disch_done};

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
		end
	end

	logic [1:0] cc1_s;
	logic [1:0] cc2_s;
	logic wake_s;
	logic uv_s;
	logic benp_s;
	logic vsrc_s;
	logic ovp_s;
	logic ocp_s;
	logic disch_s;
	assign cc1_s = sync2_q[10:9];
	assign cc2_s = sync2_q[8:7];
	assign wake_s = sync2_q[6];
	assign uv_s = sync2_q[5];
	assign benp_s = sync2_q[4];
	assign vsrc_s = sync2_q[3];
	assign ovp_s = sync2_q[2];
	assign ocp_s = sync2_q[1];
	assign disch_s = sync2_q[0];

	// System reset: enable low or supply undervoltage.
	logic sys_clr;
	assign sys_clr = !wake_s || uv_s;
	assign standby = !wake_s;

	// Software registers.
	logic [31:0] ctrl_q;
	logic [15:0] deb_q;
	logic [1:0] fault_q;
	logic bus_req;
	logic wr_en;
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_en = bus_req && wb_we_i;

	// Control and debounce registers, reloaded with their reset values by system reset.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= CTRL_RST;
			deb_q <= DEB_RST;
		end else if (sys_clr) begin
			ctrl_q <= CTRL_RST;
			deb_q <= DEB_RST;
		end else if (wr_en && wb_adr_i == OFS_CTRL) begin
			if (wb_sel_i[0]) begin
				ctrl_q[4:0] <= wb_dat_i[4:0];
			end
		end else if (wr_en && wb_adr_i == OFS_DEB) begin
			if (wb_sel_i[0]) begin
				deb_q[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				deb_q[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	logic configured;
	logic buck_en_bit;
	logic vconn_feat;
	assign configured = ctrl_q[CTRL_CFG];
	assign buck_en_bit = ctrl_q[CTRL_BUCK];
	assign vconn_feat = ctrl_q[CTRL_VCONN];
	// Pullup level follows the register alone; attach is untouched.
	assign rp_sel = ctrl_q[CTRL_RP_LO +: 2];
	assign not_cfg_int = !configured;

	// Sticky cable power faults; a new fault beats a clear.
	// A system reset leaves them set, so software still sees why cable
	// power was cut after a restart.
	logic [1:0] flt_clr;
	assign flt_clr = (wr_en && wb_adr_i == OFS_FAULT && wb_sel_i[0])
		? wb_dat_i[1:0] : 2'h0;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_q <= 2'h0;
		end else begin
			fault_q[FLT_OVP] <= ovp_s ||
				(fault_q[FLT_OVP] && !flt_clr[FLT_OVP]);
			fault_q[FLT_OCP] <= ocp_s ||
				(fault_q[FLT_OCP] && !flt_clr[FLT_OCP]);
		end
	end

	// Debounce the pulldown classes before decoding.
	logic [3:0] cls_deb;
	tca_debounce #(
		.W(4)
	) u_deb (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.clr(sys_clr),
		.raw({cc1_s, cc2_s}),
		.limit(deb_q),
		.stable_q(cls_deb)
	);

	logic [1:0] c1;
	logic [1:0] c2;
	assign c1 = cls_deb[3:2];
	assign c2 = cls_deb[1:0];

	// Decode the pulldown pair into a contact code.
	logic [1:0] code_d;
	always_comb begin
		code_d = CODE_NONE;
		if (c1 == CLS_SINK && c2 != CLS_SINK) begin
			code_d = CODE_CC1;
		end else if (c2 == CLS_SINK && c1 != CLS_SINK) begin
			code_d = CODE_CC2;
		end
	end

	// Attach flags registered from the decoded code.
	logic sink_attached_flag;
	logic orientation_flag;
	logic [1:0] cc_contact_code;
	logic cable_q;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cc_contact_code <= CODE_NONE;
			sink_attached_flag <= 1'b0;
			orientation_flag <= 1'b0;
			cable_q <= 1'b0;
		end else begin
			cc_contact_code <= code_d;
			sink_attached_flag <= code_d != CODE_NONE;
			orientation_flag <= code_d == CODE_CC1;
			cable_q <= (code_d == CODE_CC1 && c2 == CLS_CABLE) ||
				(code_d == CODE_CC2 && c1 == CLS_CABLE);
		end
	end

	// Open-drain orientation pin pulls low for a CC2 sink.
	assign orient_o = 1'b0;
	assign orient_oe = cc_contact_code == CODE_CC2;

	// Converter permission and request.
	logic buck_permit;
	logic run_req;
	assign buck_permit = benp_s && buck_en_bit;
	assign run_req = sink_attached_flag && buck_permit &&
		configured && wake_s;

	// Power sequencer with gate lead and discharge tail.
	// A request lost in the lead phase drops straight back to off, since
	// the converter never started and there is nothing to bleed.
	tca_seq_t seq_q;
	logic [15:0] lead_q;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			seq_q <= SQ_OFF;
			lead_q <= '0;
		end else begin
			unique case (seq_q)
				SQ_OFF: begin
					lead_q <= '0;
					if (run_req) begin
						seq_q <= SQ_GATE;
					end
				end
				SQ_GATE: begin
					lead_q <= lead_q + 16'h0001;
					if (!run_req) begin
						seq_q <= SQ_OFF;
					end else if (lead_q >= GATE_LEAD_N - 16'h0001) begin
						seq_q <= SQ_RUN;
					end
				end
				SQ_RUN: begin
					if (!run_req) begin
						seq_q <= SQ_DISCH;
					end
				end
				SQ_DISCH: begin
					if (disch_s) begin
						seq_q <= SQ_OFF;
					end
				end
			endcase
		end
	end

	// Gate stays on from the lead phase until discharge completes.
	assign ext_fet_gate_drive = seq_q != SQ_OFF;
	assign buck_run = seq_q == SQ_RUN;

	// Cable power onto the pin without the channel wire.
	logic vconn_ok;
	assign vconn_ok = vconn_feat && vsrc_s && cable_q &&
		sink_attached_flag && fault_q == 2'h0 &&
		!ovp_s && !ocp_s;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			vconn_cc1_en <= 1'b0;
			vconn_cc2_en <= 1'b0;
		end else begin
			vconn_cc1_en <= vconn_ok &&
				cc_contact_code == CODE_CC2;
			vconn_cc2_en <= vconn_ok &&
				cc_contact_code == CODE_CC1;
		end
	end

	// Status word.
	logic [31:0] stat_w;
	always_comb begin
		stat_w = 32'h0000_0000;
		stat_w[ST_ATT] = sink_attached_flag;
		stat_w[ST_ORI] = orientation_flag;
		stat_w[ST_CODE +: 2] = cc_contact_code;
		stat_w[ST_VBUS] = buck_run;
		stat_w[ST_VC1] = vconn_cc1_en;
		stat_w[ST_VC2] = vconn_cc2_en;
		stat_w[ST_GATE] = ext_fet_gate_drive;
		stat_w[ST_PERMIT] = buck_permit;
		stat_w[ST_OVP] = fault_q[FLT_OVP];
		stat_w[ST_OCP] = fault_q[FLT_OCP];
		stat_w[ST_NCFG] = !configured;
	end

	// Read mux; unmapped addresses read zero.
	logic [31:0] rd_w;
	always_comb begin
		unique case (wb_adr_i)
			OFS_CTRL: rd_w = ctrl_q;
			OFS_DEB: rd_w = {16'h0000, deb_q};
			OFS_STAT: rd_w = stat_w;
			OFS_FAULT: rd_w = {30'h0000_0000, fault_q};
			default: rd_w = 32'h0000_0000;
		endcase
	end

	// One-cycle acknowledge with registered read data.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i) begin
				wb_dat_o <= rd_w;
			end
		end
	end
endmodule // tca_attach
`default_nettype wire

// File: tb/tca_attach_checker.sv
// Port assertions for the Type-C attach logic.
`timescale 1ns/10ps
`default_nettype none
module tca_attach_checker (
	input wire logic ref_clk, // Clock.
	input wire logic arst_n, // Reset, active low.
	input wire logic vconn_ovp, // Cable power overvoltage.
	input wire logic standby, // Standby.
	input wire logic not_cfg_int, // Not configured.
	input wire logic ext_fet_gate_drive, // Gate drive.
	input wire logic buck_run, // Converter on.
	input wire logic vconn_cc1_en, // Cable power on CC1.
	input wire logic vconn_cc2_en, // Cable power on CC2.
	input wire logic orient_o, // Orientation level.
	input wire logic orient_oe // Orientation pull.
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// Relations between the power, cable power and orientation outputs.
	AST_VC_EXCL: assert property (!(vconn_cc1_en && vconn_cc2_en))
		else $error("cable power on both pins");
	AST_VC_SIDE: assert property ($rose(vconn_cc2_en) |-> !orient_oe)
		else $error("cable power on the sink pin");
	AST_OD_LOW: assert property (orient_oe |-> !orient_o)
		else $error("orientation pin driven high");
	AST_RUN_GATE: assert property (buck_run |-> ext_fet_gate_drive)
		else $error("converter on without gate");
	AST_GATE_LEAD: assert property ($rose(ext_fet_gate_drive) |-> !buck_run [*8])
		else $error("gate lead too short");
	AST_GATE_HOLD: assert property ($fell(buck_run) |-> ext_fet_gate_drive [*2])
		else $error("gate off before discharge");
	AST_CFG_HOLD: assert property ($rose(buck_run) |-> !not_cfg_int)
		else $error("converter on before configuration");
	AST_SBY_RST: assert property ($rose(standby) |-> ##[0:4] not_cfg_int)
		else $error("standby without system reset");
	AST_VC_FLT: assert property (vconn_ovp |-> ##[1:5] !(vconn_cc1_en || vconn_cc2_en))
		else $error("cable power kept on a fault");
endmodule // tca_attach_checker
bind tca_attach tca_attach_checker i_tca_attach_checker (.ref_clk, .arst_n,
	.vconn_ovp, .standby, .not_cfg_int, .ext_fet_gate_drive, .buck_run,
	.vconn_cc1_en, .vconn_cc2_en, .orient_o, .orient_oe);
`default_nettype wire

// File: tb/tca_sink_model.sv
// Behavioural sink, cable or accessory at the CC pins.
`timescale 1ns/10ps
`default_nettype none
module tca_sink_model (
	input wire logic ref_clk, // Clock.
	input wire logic [1:0] plug1, // Termination on CC1.
	input wire logic [1:0] plug2, // Termination on CC2.
	input wire logic ext_fet_gate_drive, // Gate drive seen.
	input wire logic buck_run, // Converter on seen.
	input wire logic [7:0] dly, // Discharge time in cycles.
	output logic [1:0] cc1_class, // Class at CC1.
	output logic [1:0] cc2_class, // Class at CC2.
	output logic disch_done // Discharge finished.
);
	logic [7:0] cnt_q;
	// The terminations are what is plugged in.
	assign cc1_class = plug1;
	assign cc2_class = plug2;
	// The output bleeds down for dly cycles once the converter stops.
	always_ff @(posedge ref_clk) begin
		if (buck_run || !ext_fet_gate_drive)
			cnt_q <= 8'h00;
		else if (cnt_q != dly)
			cnt_q <= cnt_q + 8'h01;
	end
	assign disch_done = ext_fet_gate_drive && !buck_run && cnt_q == dly;
endmodule // tca_sink_model
`default_nettype wire

// File: tb/tca_attach_tb.sv
// Self-checking bench for the Type-C attach logic.
`timescale 1ns/10ps
`default_nettype none
module tca_attach_tb
	import tca_pkg::*;
;
	logic ref_clk = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_we_i = 1'b0;
	logic system_wake_enable = 1'b1, buck_enable_pin = 1'b1;
	logic vconn_src_ok = 1'b1, vconn_ovp = 1'b0, vconn_ocp = 1'b0;
	logic bias_uv = 1'b0;
	logic [7:0] wb_adr_i = 8'h00, dly = 8'h02;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd_q;
	logic [1:0] plug1 = 2'h0, plug2 = 2'h0, cc1_class, cc2_class, rp_sel;
	logic wb_ack_o, disch_done, standby, not_cfg_int, ext_fet_gate_drive;
	logic buck_run, vconn_cc1_en, vconn_cc2_en, orient_o, orient_oe;
	int err_total = 0, check_count = 0;

	tca_attach i_tca_attach (.ref_clk, .arst_n, .wb_cyc_i, .wb_stb_i(wb_cyc_i),
		.wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.cc1_class, .cc2_class, .system_wake_enable, .bias_uv,
		.buck_enable_pin, .vconn_src_ok, .vconn_ovp, .vconn_ocp, .disch_done,
		.rp_sel, .standby, .not_cfg_int, .ext_fet_gate_drive, .buck_run,
		.vconn_cc1_en, .vconn_cc2_en, .orient_o, .orient_oe);
	tca_sink_model i_tca_sink_model (.ref_clk, .plug1, .plug2,
		.ext_fet_gate_drive, .buck_run, .dly, .cc1_class, .cc2_class,
		.disch_done);

	// Free-running 50 MHz clock.
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic report_and_stop();
		if (err_total == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic stuck();
		err_total++;
		report_and_stop();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	// One classic cycle, held until ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50)
			stuck();
		rd_q = wb_dat_o;
		wb_cyc_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(rd_q, e);
	endtask
	task automatic wait_for(ref logic s, input logic v);
		int n;
		n = 0;
		while (s !== v && n < 2000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 2000)
			stuck();
	endtask

	// Every pair of terminations on the two pins.
	task automatic pins_all();
		logic s1, s2, a;
		wb(1'b1, OFS_CTRL, 32'h0000_0013);
		for (int i = 0; i < 9; i++) begin
			plug1 <= 2'(i / 3);
			plug2 <= 2'(i % 3);
			repeat (16) @(posedge ref_clk);
			s1 = plug1 == CLS_SINK && plug2 != CLS_SINK;
			s2 = plug2 == CLS_SINK && plug1 != CLS_SINK;
			a = s1 | s2;
			chkb(orient_oe, s2);
			rd(OFS_STAT, {23'h0, 1'b1, a, s1 && plug2 == CLS_CABLE,
				s2 && plug1 == CLS_CABLE, 1'b0, s2, s1, s1, a});
			plug1 <= CLS_OPEN;
			plug2 <= CLS_OPEN;
			repeat (16) @(posedge ref_clk);
			chkb(ext_fet_gate_drive, 1'b0);
		end
	endtask
	// Power-up, pullup changes while running, then a slow discharge.
	task automatic run_seq();
		plug1 <= CLS_SINK;
		dly <= 8'h30;
		wait_for(buck_run, 1'b1);
		for (int r = 0; r < 3; r++) begin
			wb(1'b1, OFS_CTRL, 32'h0000_0013 | 32'(r << 2));
			repeat (2) @(posedge ref_clk);
			chk({30'h0, rp_sel}, 32'(r));
			chkb(buck_run, 1'b1);
		end
		wb(1'b1, OFS_CTRL, 32'h0000_0011);
		wait_for(buck_run, 1'b0);
		chkb(ext_fet_gate_drive, 1'b1);
		wait_for(ext_fet_gate_drive, 1'b0);
		dly <= 8'h02;
	endtask
	// Cable power faults cut the supply and stick until cleared.
	task automatic faults();
		wb(1'b1, OFS_CTRL, 32'h0000_0013);
		plug2 <= CLS_CABLE;
		for (int f = 0; f < 2; f++) begin
			wait_for(vconn_cc2_en, 1'b1);
			{vconn_ocp, vconn_ovp} <= 2'(1 << f);
			repeat (8) @(posedge ref_clk);
			chkb(vconn_cc2_en, 1'b0);
			{vconn_ocp, vconn_ovp} <= 2'h0;
			rd(OFS_FAULT, 32'(1 << f));
			wb(1'b1, OFS_FAULT, 32'h0000_0003);
			rd(OFS_FAULT, 32'h0000_0000);
		end
		vconn_src_ok <= 1'b0;
		repeat (8) @(posedge ref_clk);
		chkb(vconn_cc2_en, 1'b0);
		vconn_src_ok <= 1'b1;
		wait_for(vconn_cc2_en, 1'b1);
		wb(1'b1, OFS_CTRL, 32'h0000_0003);
		repeat (8) @(posedge ref_clk);
		chkb(vconn_cc2_en, 1'b0);
	endtask
	// Supply undervoltage is a system reset as well.
	task automatic uv_drop();
		bias_uv <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chkb(not_cfg_int, 1'b1);
		chkb(buck_run, 1'b0);
		bias_uv <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rd(OFS_CTRL, CTRL_RST);
	endtask
	// Enable toggle resets configuration and holds the converter off.
	task automatic wake_off();
		system_wake_enable <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chkb(standby, 1'b1);
		chkb(not_cfg_int, 1'b1);
		system_wake_enable <= 1'b1;
		plug1 <= CLS_OPEN;
		plug2 <= CLS_SINK;
		repeat (4) @(posedge ref_clk);
		rd(OFS_CTRL, CTRL_RST);
		repeat (600) @(posedge ref_clk);
		chkb(buck_run, 1'b0);
		wb(1'b1, OFS_CTRL, 32'h0000_0003);
		wait_for(buck_run, 1'b1);
	endtask

	// Main sequence.
	initial begin
		repeat (12) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chkb(not_cfg_int, 1'b1);
		rd(OFS_CTRL, CTRL_RST);
		rd(8'h10, 32'h0000_0000);
		wb(1'b1, OFS_DEB, 32'h0000_0002);
		rd(OFS_DEB, 32'h0000_0002);
		pins_all();
		run_seq();
		faults();
		wake_off();
		uv_drop();
		report_and_stop();
	end
endmodule // tca_attach_tb
`default_nettype wire
